// ==== crtch_pkg.sv ====
// package: address map, indices, reset values and timing constants of the horizontal timing block
package crtch_pkg;
  // ----------------------------------------------------------------
  // host port addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] CRTCH_IO_IDX_MONO = 16'h03B4; // index port, mono emulation
  localparam logic [15:0] CRTCH_IO_DAT_MONO = 16'h03B5; // data port, mono emulation
  localparam logic [15:0] CRTCH_IO_IDX_COL = 16'h03D4; // index port, colour emulation
  localparam logic [15:0] CRTCH_IO_DAT_COL = 16'h03D5; // data port, colour emulation
  localparam logic [15:0] CRTCH_MM_IDX_MONO = 16'h03B4; // memory offset, index, mono
  localparam logic [15:0] CRTCH_MM_DAT_MONO = 16'h03B5; // memory offset, data, mono
  localparam logic [15:0] CRTCH_MM_IDX_COL = 16'h03D3; // memory offset, index, colour
  localparam logic [15:0] CRTCH_MM_DAT_COL = 16'h03D5; // memory offset, data, colour

  // ----------------------------------------------------------------
  // controller register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] CRTCH_IX_HTOTAL = 8'h00; // horizontal_total
  localparam logic [7:0] CRTCH_IX_HDEND = 8'h01; // horizontal_display_end
  localparam logic [7:0] CRTCH_IX_HBSTART = 8'h02; // horizontal_blank_start
  localparam logic [7:0] CRTCH_IX_HBEND = 8'h03; // horizontal_blank_end
  localparam logic [7:0] CRTCH_IX_HSSTART = 8'h04; // horizontal_sync_start
  localparam logic [7:0] CRTCH_IX_HSEND = 8'h05; // horizontal_sync_end
  localparam logic [7:0] CRTCH_IX_PROT_LAST = 8'h07; // last index of protected group
  localparam logic [7:0] CRTCH_IX_VRETEND = 8'h11; // vertical_retrace_end
  localparam logic [7:0] CRTCH_IX_HEXTA = 8'h35; // horizontal_extension_a
  localparam logic [7:0] CRTCH_IX_HEXTB = 8'h39; // horizontal_extension_b
  localparam logic [7:0] CRTCH_IX_EXTCTL = 8'h80; // extension_control

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CRTCH_PROT_BIT = 7; // write protect in vertical_retrace_end
  localparam int CRTCH_HBEND_FIXED_BIT = 7; // blanking end bit that always reads one
  localparam int CRTCH_HSEND_BEMSB_BIT = 7; // blanking end msb in horizontal_sync_end
  localparam int CRTCH_SKEW_LSB = 5; // skew / sync delay field, bits 6:5
  localparam int CRTCH_EXT_EN_BIT = 0; // extension enable in extension_control

  // ----------------------------------------------------------------
  // reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] CRTCH_RST_ZERO = 8'h00; // default of all held registers except blanking end
  localparam logic [7:0] CRTCH_RST_HBEND = 8'h80; // blanking end reads 1 in bit 7
  localparam logic [8:0] CRTCH_TOTAL_ADJ = 9'h004; // total+5 clocks: wrap at total+4
  localparam int CRTCH_CHAR_DOTS = 8; // reference cycles per character clock
endpackage : crtch_pkg

// ==== crtch_horiz.sv ====
// module: indexed controller access port and horizontal character timing generator
//
// Summary of operation
// (RULE_01) hold 8-bit index selecting data port target
// (RULE_02) i/o ports 3B4/3B5 or 3D4/3D5 by colour
// (RULE_03) memory index 3B4/3D3, data 3B5/3D5
// (RULE_04) protect bit blocks writes to indices 0-7
// (RULE_05) extension control gates extended registers
// (RULE_06) software: total = characters per line minus 5
// (RULE_07) software: display end = active characters minus 1
// (RULE_08) software: blank start counted from active start
// (RULE_09) blank end bit 7 ignores writes, reads 1
// (RULE_10) skew delays display enable 0 to 3
// (RULE_11) blank end 6 bits: low five here
// (RULE_12) software: blank end = start plus length
// (RULE_13) software: sync start counted from active start
// (RULE_14) blank end msb from sync end bit 7
// (RULE_15) counter matches start/end values for blank, sync
// (RULE_16) counter restarts after total plus 5 characters
`timescale 1ns/10ps
module crtch_horiz #(
  parameter int CHAR_DIV = crtch_pkg::CRTCH_CHAR_DOTS // reference cycles per character
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [15:0] bus_addr,
  input wire logic bus_mem,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic colour_emulation,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  output logic [8:0] hcount,
  output logic hde,
  output logic hblank,
  output logic hsync
);
  import crtch_pkg::*;
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] controller_index_reg; // selects target of the data port
  logic [7:0] horizontal_total_reg; // characters per line minus 5
  logic [7:0] horizontal_display_end_reg; // active characters minus 1
  logic [7:0] horizontal_blank_start_reg; // blank start position
  logic [6:0] horizontal_blank_end_reg; // skew in 6:5, blank end low bits in 4:0
  logic [7:0] horizontal_sync_start_reg; // sync start position
  logic [7:0] horizontal_sync_end_reg; // blank end msb, sync delay, sync end
  logic [7:0] vertical_retrace_end_reg; // only the protect bit matters here
  logic [7:0] horizontal_extension_a_reg; // held for extended software
  logic [7:0] horizontal_extension_b_reg; // held for extended software
  logic [7:0] extension_control_reg; // bit 0 opens the extended set
  logic [$clog2(CHAR_DIV)-1:0] div_reg; // character clock divider
  logic char_en_reg; // one-cycle character clock enable
  logic [8:0] hcnt_reg; // horizontal character counter
  logic blank_reg; // undelayed blanking state
  logic sync_reg; // undelayed sync state
  logic [2:0] de_pipe_reg; // display enable delayed 1..3 characters
  logic [2:0] sync_pipe_reg; // sync delayed 1..3 characters
  logic de_raw; // counter inside active area
  logic [5:0] blank_end6; // assembled 6-bit blank end
  logic [1:0] skew; // display enable skew
  logic [1:0] sync_dly; // sync delay
  logic idx_hit; // access falls on the index port
  logic dat_hit; // access falls on the data port
  logic protect; // group of indices 0..7 locked
  logic ext_en; // extended registers reachable
  logic [7:0] rd_field; // data port read value

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // port decode; mono and colour use different address pairs
  function automatic logic port_hit(input logic [15:0] a, input logic mem, input logic col,
                                    input logic data);
    logic [15:0] want;
    want = 16'h0000;
    if (mem) begin
      want = data ? (col ? CRTCH_MM_DAT_COL : CRTCH_MM_DAT_MONO) // RULE_03
                  : (col ? CRTCH_MM_IDX_COL : CRTCH_MM_IDX_MONO);
    end else begin
      want = data ? (col ? CRTCH_IO_DAT_COL : CRTCH_IO_DAT_MONO) // RULE_02
                  : (col ? CRTCH_IO_IDX_COL : CRTCH_IO_IDX_MONO);
    end
    return a == want;
  endfunction : port_hit

  // pick the undelayed level or one of the three delayed copies
  function automatic logic skew_pick(input logic now, input logic [2:0] pipe,
                                     input logic [1:0] sel);
    logic r;
    r = now;
    case (sel)
      2'b01: r = pipe[0];
      2'b10: r = pipe[1];
      2'b11: r = pipe[2];
      default: r = now;
    endcase
    return r;
  endfunction : skew_pick

  // ----------------------------------------------------------------
  // combinational decode
  // ----------------------------------------------------------------
  assign idx_hit = port_hit(bus_addr, bus_mem, colour_emulation, 1'b0);
  assign dat_hit = port_hit(bus_addr, bus_mem, colour_emulation, 1'b1);
  assign protect = vertical_retrace_end_reg[CRTCH_PROT_BIT]; // RULE_04
  assign ext_en = extension_control_reg[CRTCH_EXT_EN_BIT]; // RULE_05
  assign skew = horizontal_blank_end_reg[CRTCH_SKEW_LSB +: 2];
  assign sync_dly = horizontal_sync_end_reg[CRTCH_SKEW_LSB +: 2];
  // msb from sync end, low five from blank end
  assign blank_end6 = {horizontal_sync_end_reg[CRTCH_HSEND_BEMSB_BIT], // RULE_14
                       horizontal_blank_end_reg[4:0]}; // RULE_11
  assign de_raw = hcnt_reg <= {1'b0, horizontal_display_end_reg};

  // read mux; unknown indices, and extended ones while closed, read zero
  always_comb begin
    rd_field = CRTCH_RST_ZERO;
    case (controller_index_reg)
      CRTCH_IX_HTOTAL: rd_field = horizontal_total_reg;
      CRTCH_IX_HDEND: rd_field = horizontal_display_end_reg;
      CRTCH_IX_HBSTART: rd_field = horizontal_blank_start_reg;
      CRTCH_IX_HBEND: rd_field = {1'b1, horizontal_blank_end_reg}; // RULE_09
      CRTCH_IX_HSSTART: rd_field = horizontal_sync_start_reg;
      CRTCH_IX_HSEND: rd_field = horizontal_sync_end_reg;
      CRTCH_IX_VRETEND: rd_field = vertical_retrace_end_reg;
      CRTCH_IX_EXTCTL: rd_field = extension_control_reg;
      CRTCH_IX_HEXTA: rd_field = ext_en ? horizontal_extension_a_reg : CRTCH_RST_ZERO; // RULE_05
      CRTCH_IX_HEXTB: rd_field = ext_en ? horizontal_extension_b_reg : CRTCH_RST_ZERO;
      default: rd_field = CRTCH_RST_ZERO;
    endcase
  end

  // ----------------------------------------------------------------
  // index register
  // ----------------------------------------------------------------
  // any write to the index port replaces the index whole
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      controller_index_reg <= CRTCH_RST_ZERO;
    end else if (bus_wr && idx_hit) begin
      controller_index_reg <= bus_wdata; // RULE_01
    end
  end

  // ----------------------------------------------------------------
  // data port writes
  // ----------------------------------------------------------------
  // indices 0..7 are locked while protect is set; the protect bit itself
  // sits outside the group so software can always unlock
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      horizontal_total_reg <= CRTCH_RST_ZERO;
      horizontal_display_end_reg <= CRTCH_RST_ZERO;
      horizontal_blank_start_reg <= CRTCH_RST_ZERO;
      horizontal_blank_end_reg <= CRTCH_RST_HBEND[6:0];
      horizontal_sync_start_reg <= CRTCH_RST_ZERO;
      horizontal_sync_end_reg <= CRTCH_RST_ZERO;
      vertical_retrace_end_reg <= CRTCH_RST_ZERO;
      horizontal_extension_a_reg <= CRTCH_RST_ZERO;
      horizontal_extension_b_reg <= CRTCH_RST_ZERO;
      extension_control_reg <= CRTCH_RST_ZERO;
    end else if (bus_wr && dat_hit) begin
      if (!(protect && controller_index_reg <= CRTCH_IX_PROT_LAST)) begin // RULE_04
        case (controller_index_reg)
          CRTCH_IX_HTOTAL: horizontal_total_reg <= bus_wdata;
          CRTCH_IX_HDEND: horizontal_display_end_reg <= bus_wdata;
          CRTCH_IX_HBSTART: horizontal_blank_start_reg <= bus_wdata;
          // bit 7 is dropped; it is not stored at all
          CRTCH_IX_HBEND: horizontal_blank_end_reg <= bus_wdata[6:0]; // RULE_09
          CRTCH_IX_HSSTART: horizontal_sync_start_reg <= bus_wdata;
          CRTCH_IX_HSEND: horizontal_sync_end_reg <= bus_wdata;
          CRTCH_IX_VRETEND: vertical_retrace_end_reg <= bus_wdata;
          CRTCH_IX_EXTCTL: extension_control_reg <= bus_wdata;
          CRTCH_IX_HEXTA: begin
            if (ext_en) horizontal_extension_a_reg <= bus_wdata; // RULE_05
          end
          CRTCH_IX_HEXTB: begin
            if (ext_en) horizontal_extension_b_reg <= bus_wdata;
          end
          default: ; // unmapped index, write dropped
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  // answer one cycle after the strobe; data holds until the next read
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      bus_rdata <= CRTCH_RST_ZERO;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= bus_rd && (idx_hit || dat_hit);
      if (bus_rd && idx_hit) begin
        bus_rdata <= controller_index_reg;
      end else if (bus_rd && dat_hit) begin
        bus_rdata <= rd_field;
      end
    end
  end

  // ----------------------------------------------------------------
  // character clock
  // ----------------------------------------------------------------
  // a single clock domain; the character rate is an enable pulse
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
      char_en_reg <= 1'b0;
    end else begin
      char_en_reg <= div_reg == ($clog2(CHAR_DIV))'(CHAR_DIV - 1);
      div_reg <= (div_reg == ($clog2(CHAR_DIV))'(CHAR_DIV - 1)) ? '0 : div_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // horizontal counter
  // ----------------------------------------------------------------
  // line length is total+5 characters, so the last count is total+4;
  // a total lowered below the count still wraps via the >= compare
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hcnt_reg <= '0;
    end else if (char_en_reg) begin
      if (hcnt_reg >= {1'b0, horizontal_total_reg} + CRTCH_TOTAL_ADJ) begin // RULE_16
        hcnt_reg <= '0;
      end else begin
        hcnt_reg <= hcnt_reg + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // blanking and sync state
  // ----------------------------------------------------------------
  // start compares all bits; end compares only the low 6 (blank) or 5 (sync)
  // bits, so the end may fall after a counter wrap
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      blank_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else if (char_en_reg) begin
      if (hcnt_reg == {1'b0, horizontal_blank_start_reg}) begin
        blank_reg <= 1'b1; // RULE_15
      end else if (hcnt_reg[5:0] == blank_end6) begin
        blank_reg <= 1'b0; // RULE_15
      end
      if (hcnt_reg == {1'b0, horizontal_sync_start_reg}) begin
        sync_reg <= 1'b1; // RULE_15
      end else if (hcnt_reg[4:0] == horizontal_sync_end_reg[4:0]) begin
        sync_reg <= 1'b0; // RULE_15
      end
    end
  end

  // ----------------------------------------------------------------
  // skew pipelines
  // ----------------------------------------------------------------
  // delays are whole characters, so the pipes step on the character enable
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      de_pipe_reg <= '0;
      sync_pipe_reg <= '0;
    end else if (char_en_reg) begin
      de_pipe_reg <= {de_pipe_reg[1:0], de_raw}; // RULE_10
      sync_pipe_reg <= {sync_pipe_reg[1:0], sync_reg};
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hcount <= '0;
      hde <= 1'b0;
      hblank <= 1'b0;
      hsync <= 1'b0;
    end else begin
      hcount <= hcnt_reg;
      hde <= skew_pick(de_raw, de_pipe_reg, skew); // RULE_10
      hblank <= blank_reg;
      hsync <= skew_pick(sync_reg, sync_pipe_reg, sync_dly);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_char_at_blank_start;
    char_en_reg && hcnt_reg == {1'b0, horizontal_blank_start_reg};
  endsequence
  sequence s_char_at_last;
    char_en_reg && hcnt_reg == {1'b0, horizontal_total_reg} + CRTCH_TOTAL_ADJ;
  endsequence
  AST_INDEX_LOAD: assert property ( // RULE_01
    bus_wr && idx_hit |=> controller_index_reg == $past(bus_wdata))
    else $error("index not loaded from index port write");
  AST_IO_WRONG_PAIR: assert property ( // RULE_02
    bus_wr && !bus_mem && !colour_emulation && bus_addr == CRTCH_IO_IDX_COL
    |=> $stable(controller_index_reg))
    else $error("colour index port answered in mono emulation");
  AST_MM_COLOUR_INDEX: assert property ( // RULE_03
    bus_wr && bus_mem && colour_emulation && bus_addr == CRTCH_MM_IDX_COL
    |=> controller_index_reg == $past(bus_wdata))
    else $error("memory mapped colour index not taken");
  AST_PROTECT_TOTAL: assert property ( // RULE_04
    bus_wr && dat_hit && protect && controller_index_reg == CRTCH_IX_HTOTAL
    |=> $stable(horizontal_total_reg))
    else $error("protected register was written");
  AST_EXT_CLOSED_READ: assert property ( // RULE_05
    bus_rd && dat_hit && !ext_en && controller_index_reg == CRTCH_IX_HEXTA
    |=> bus_rvalid && bus_rdata == CRTCH_RST_ZERO)
    else $error("extended register visible while disabled");
  AST_HBEND_BIT7: assert property ( // RULE_09
    bus_rd && dat_hit && controller_index_reg == CRTCH_IX_HBEND
    |=> bus_rdata[CRTCH_HBEND_FIXED_BIT])
    else $error("blank end bit 7 did not read one");
  AST_NO_SKEW_LINE_START: assert property ( // RULE_10
    hcnt_reg == '0 && skew == 2'b00 |=> hde)
    else $error("display enable missing at line start with no skew");
  AST_BLANK_STARTS: assert property ( // RULE_15
    s_char_at_blank_start |=> blank_reg ##1 hblank)
    else $error("blanking did not start on match");
  AST_BLANK_ENDS: assert property ( // RULE_11 RULE_14
    char_en_reg && blank_reg && hcnt_reg[5:0] == blank_end6
    && hcnt_reg != {1'b0, horizontal_blank_start_reg} |=> !blank_reg)
    else $error("blanking did not end on 6-bit match");
  AST_LINE_WRAP: assert property ( // RULE_16
    s_char_at_last |=> hcnt_reg == '0 ##1 hcount == '0)
    else $error("counter did not restart after total plus 5");
endmodule : crtch_horiz

// ==== tb_crtch_horiz.sv ====
// testbench: register port and horizontal timing checks of the character timing block
`timescale 1ns/10ps
module tb_crtch_horiz;
  import crtch_pkg::*;

  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  localparam int DIV = 2; // short character clock keeps the run brief
  logic ref_clk; // reference clock
  logic resetn; // active low reset
  logic [15:0] bus_addr; // host address
  logic bus_mem; // memory decode select
  logic bus_wr; // write strobe
  logic bus_rd; // read strobe
  logic [7:0] bus_wdata; // write data
  logic colour_emulation; // colour address set
  logic [7:0] bus_rdata; // read data
  logic bus_rvalid; // read answer pulse
  logic [8:0] hcount; // character counter copy
  logic hde; // display enable
  logic hblank; // blanking
  logic hsync; // sync
  int n_fail; // mismatches
  int samples_checked; // comparisons made
  int cycles; // hang guard
  int cur; // current address mode
  logic [7:0] exp_q[$]; // expected read data, oldest first
  logic [15:0] rnd; // random stream state
  logic [15:0] ia[4]; // index port per mode
  logic [15:0] da[4]; // data port per mode

  crtch_horiz #(.CHAR_DIV(DIV)) DUT (.ref_clk(ref_clk), .resetn(resetn), .bus_addr(bus_addr),
    .bus_mem(bus_mem), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
    .colour_emulation(colour_emulation), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .hcount(hcount), .hde(hde), .hblank(hblank), .hsync(hsync));

  // ----------------------------------------------------------------
  // clock, guard and helpers
  // ----------------------------------------------------------------
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  // generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      print_verdict();
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  task automatic chk(input logic [8:0] e, input logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk

  task automatic print_verdict();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // one strobe per call; the strobe drops a full cycle before the next can rise
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge ref_clk);
    bus_wr = 1'b0;
  endtask : wr

  // a read noted with on=0 must draw no answer at all
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input bit on);
    @(negedge ref_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    if (on) begin
      exp_q.push_back(e);
    end
    @(negedge ref_clk);
    bus_rd = 1'b0;
  endtask : rd

  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    wr(ia[cur], i);
    wr(da[cur], d);
  endtask : wreg

  task automatic rreg(input logic [7:0] i, input logic [7:0] e);
    wr(ia[cur], i);
    rd(da[cur], e, 1'b1);
  endtask : rreg

  task automatic mode(input int m);
    @(negedge ref_clk);
    cur = m;
    bus_mem = (m >= 2);
    colour_emulation = m[0];
  endtask : mode

  // align to the first cycle of a line, then profile one 8-character line
  task automatic measure(output int nb, output int ns, output int nd, output int off,
                         output int mx);
    int k;
    logic pv;
    logic hp;
    nb = 0;
    ns = 0;
    nd = 0;
    off = -1;
    mx = 0;
    k = 0;
    pv = 1'b0;
    hp = 1'b0;
    while (k < 100 && !(pv && hcount === 9'h000)) begin
      pv = (hcount !== 9'h000);
      hp = hde;
      @(negedge ref_clk);
      k++;
    end
    for (int j = 0; j < 8 * DIV; j++) begin
      nb += int'(hblank);
      ns += int'(hsync);
      nd += int'(hde);
      if (int'(hcount) > mx) mx = int'(hcount);
      if (hde === 1'b1 && hp === 1'b0 && off < 0) off = j;
      hp = hde;
      @(negedge ref_clk);
    end
  endtask : measure

  // ----------------------------------------------------------------
  // answer watcher: every read pulse consumes the oldest note
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (bus_rvalid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk(9'h000, {8'h00, bus_rvalid});
      end else begin
        chk({1'b0, exp_q.pop_front()}, {1'b0, bus_rdata});
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int nb;
    int ns;
    int nd;
    int o0;
    int o2;
    int mx;
    logic [7:0] d;
    ia = '{CRTCH_IO_IDX_MONO, CRTCH_IO_IDX_COL, CRTCH_MM_IDX_MONO, CRTCH_MM_IDX_COL};
    da = '{CRTCH_IO_DAT_MONO, CRTCH_IO_DAT_COL, CRTCH_MM_DAT_MONO, CRTCH_MM_DAT_COL};
    resetn = 1'b0;
    bus_addr = 16'h0000;
    bus_mem = 1'b0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
    colour_emulation = 1'b0;
    rnd = 16'hCC62;
    n_fail = 0;
    samples_checked = 0;
    cycles = 0;
    cur = 0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    rd(CRTCH_IO_DAT_MONO, CRTCH_RST_ZERO, 1'b1);
    rreg(CRTCH_IX_HBEND, CRTCH_RST_HBEND);
    // every address mode, random bytes into timing registers 0 to 4
    for (int m = 0; m < 4; m++) begin
      mode(m);
      for (int i = 0; i < 5; i++) begin
        d = rnd[7:0];
        rnd = lfsr_next(rnd);
        wreg(8'(i), d);
        rreg(8'(i), (i == 3) ? (d | 8'h80) : d);
        rd(ia[m], 8'(i), 1'b1);
      end
    end
    // ports of the other emulation or decode kind are ignored
    mode(1);
    wreg(CRTCH_IX_HTOTAL, 8'h33);
    wr(CRTCH_IO_IDX_MONO, 8'h02);
    rd(CRTCH_IO_DAT_MONO, 8'h00, 1'b0);
    rd(CRTCH_IO_DAT_COL, 8'h33, 1'b1);
    mode(3);
    wr(CRTCH_IO_IDX_COL, 8'h02);
    rd(CRTCH_MM_DAT_COL, 8'h33, 1'b1);
    // colour index port must stay deaf in mono emulation
    mode(0);
    wr(CRTCH_IO_IDX_COL, 8'h02);
    rd(CRTCH_IO_DAT_MONO, 8'h33, 1'b1);
    // timing: 8-character line, blank over counts 3..5, sync 5..6, active 0..3
    mode(1);
    wreg(CRTCH_IX_HTOTAL, 8'h03);
    wreg(CRTCH_IX_HDEND, 8'h03);
    wreg(CRTCH_IX_HBSTART, 8'h02);
    wreg(CRTCH_IX_HBEND, 8'h05);
    wreg(CRTCH_IX_HSSTART, 8'h04);
    wreg(CRTCH_IX_HSEND, 8'h06);
    repeat (40) @(negedge ref_clk);
    measure(nb, ns, nd, o0, mx);
    chk(9'h007, 9'(mx));
    chk(9'(3 * DIV), 9'(nb));
    chk(9'(2 * DIV), 9'(ns));
    chk(9'(4 * DIV), 9'(nd));
    wreg(CRTCH_IX_HBEND, 8'h45);
    repeat (40) @(negedge ref_clk);
    measure(nb, ns, nd, o2, mx);
    chk(9'(o0 + 2 * DIV), 9'(o2));
    chk(9'(4 * DIV), 9'(nd));
    // top end bit set: end value 37 never matches, blanking never ends;
    // sync delayed one character, so it covers counts 6..7 instead of 5..6
    wreg(CRTCH_IX_HSEND, 8'hA6);
    repeat (40) @(negedge ref_clk);
    measure(nb, ns, nd, o2, mx);
    chk(9'(8 * DIV), 9'(nb));
    chk(9'(2 * DIV), 9'(ns));
    while (hcount !== 9'h007) @(negedge ref_clk);
    chk(9'h001, {8'h00, hsync});
    // write protection of the first eight indices
    wreg(CRTCH_IX_VRETEND, 8'h80);
    wreg(CRTCH_IX_HTOTAL, 8'h5A);
    rreg(CRTCH_IX_HTOTAL, 8'h03);
    wreg(CRTCH_IX_VRETEND, 8'h00);
    wreg(CRTCH_IX_HTOTAL, 8'h5A);
    rreg(CRTCH_IX_HTOTAL, 8'h5A);
    // extended registers gated by the extension enable
    wreg(CRTCH_IX_HEXTA, 8'hA5);
    rreg(CRTCH_IX_HEXTA, 8'h00);
    wreg(CRTCH_IX_EXTCTL, 8'h01);
    wreg(CRTCH_IX_HEXTA, 8'hA5);
    wreg(CRTCH_IX_HEXTB, 8'h3C);
    rreg(CRTCH_IX_HEXTA, 8'hA5);
    rreg(CRTCH_IX_HEXTB, 8'h3C);
    wreg(8'h20, 8'hFF);
    rreg(8'h20, 8'h00);
    repeat (4) @(negedge ref_clk);
    chk(9'h000, 9'(exp_q.size()));
    print_verdict();
  end
endmodule : tb_crtch_horiz
